/* common/clock_pkg.sv */
// Package with register map, field layouts and timing constants for the calendar clock
package clock_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

    // Field indices; byte address is four times the index
    localparam logic [2:0] IDX_SECONDS = 3'h0;
    localparam logic [2:0] IDX_MINUTES = 3'h1;
    localparam logic [2:0] IDX_HOURS = 3'h2;
    localparam logic [2:0] IDX_WEEKDAY = 3'h3;
    localparam logic [2:0] IDX_DATE = 3'h4;
    localparam logic [2:0] IDX_MONTH = 3'h5;
    localparam logic [2:0] IDX_YEAR = 3'h6;
    localparam int unsigned FIELD_COUNT = 7;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // Bits each field uses; others read zero
    localparam logic [7:0] MASK_SECONDS = 8'h7f;
    localparam logic [7:0] MASK_MINUTES = 8'h7f;
    localparam logic [7:0] MASK_HOURS = 8'h3f;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;

    // Values after reset
    localparam logic [7:0] RESET_SECONDS = 8'h00;
    localparam logic [7:0] RESET_MINUTES = 8'h00;
    localparam logic [7:0] RESET_HOURS = 8'h00;
    localparam logic [7:0] RESET_WEEKDAY = 8'h01;
    localparam logic [7:0] RESET_DATE = 8'h01;
    localparam logic [7:0] RESET_MONTH = 8'h01;
    localparam logic [7:0] RESET_YEAR = 8'h00;

    // Wrap limits in BCD
    localparam logic [7:0] MAX_SECONDS = 8'h59;
    localparam logic [7:0] MAX_HOURS = 8'h23;
    localparam logic [7:0] MAX_WEEKDAY = 8'h07;
    localparam logic [7:0] MAX_DATE = 8'h31;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] FIRST_DAY = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] seconds_count;
        logic [7:0] minutes_count;
        logic [7:0] hours_count;
        logic [7:0] weekday_code;
        logic [7:0] day_of_month;
        logic [7:0] month_count;
        logic [7:0] year_count;
    } clock_fields_t;

    typedef struct packed {
        logic write;
        logic [2:0] field_index;
        logic [7:0] field_value;
    } field_write_t;

endpackage : clock_pkg

/* core/bcd_counter_step.sv */
// One BCD field step: increment with wrap and carry out
`timescale 1ns/1ns
module bcd_counter_step (
    input wire logic [7:0] value,
    input wire logic [7:0] max_value,
    input wire logic [7:0] wrap_value,
    output logic [7:0] next_value,
    output logic carry
);
    wire logic at_max = (value == max_value);
    wire logic units_wrap = (value[3:0] >= 4'h9);
    wire logic [7:0] incremented = units_wrap ? {4'(value[7:4] + 4'h1), 4'h0}
                                              : {value[7:4], 4'(value[3:0] + 4'h1)};

    assign next_value = at_max ? wrap_value : incremented;
    assign carry = at_max;
endmodule : bcd_counter_step

/* core/bcd_calendar_clock.sv */
// Calendar clock core with seven BCD fields behind an AXI4-Lite slave
`timescale 1ns/1ns
// Contract
// - Seven byte fields at indices zero to six
// - All fields held and exchanged as BCD
// - Hours count 0 to 23, no AM/PM
// - Weekday codes 1 Sunday to 7 Saturday
// - Read returns current byte of indexed field
// - Write replaces field; counting resumes from it
// - Counting continues while main power absent; the core counts only while aclk runs
module bcd_calendar_clock #(
    parameter int unsigned TICK_CYCLES = clock_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic second_tick
);

    function automatic logic [7:0] field_mask(input logic [2:0] idx);
        case (idx)
            clock_pkg::IDX_SECONDS: field_mask = clock_pkg::MASK_SECONDS;
            clock_pkg::IDX_MINUTES: field_mask = clock_pkg::MASK_MINUTES;
            clock_pkg::IDX_HOURS: field_mask = clock_pkg::MASK_HOURS;
            clock_pkg::IDX_WEEKDAY: field_mask = clock_pkg::MASK_WEEKDAY;
            clock_pkg::IDX_DATE: field_mask = clock_pkg::MASK_DATE;
            clock_pkg::IDX_MONTH: field_mask = clock_pkg::MASK_MONTH;
            clock_pkg::IDX_YEAR: field_mask = clock_pkg::MASK_YEAR;
            default: field_mask = 8'h00;
        endcase
    endfunction : field_mask

    function automatic logic is_field_addr(input logic [7:0] addr);
        is_field_addr = (addr[1:0] == 2'b00) && (addr[7:2] < 6'(clock_pkg::FIELD_COUNT));
    endfunction : is_field_addr

    clock_pkg::clock_fields_t fields;
    clock_pkg::clock_fields_t next_fields;
    logic [31:0] tick_count;
    logic [31:0] tick_total;

    // Write channel holding registers
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Write-slave handshake
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic write_go = aw_held && w_held && !s_axi_bvalid;
    wire logic write_hit = is_field_addr(aw_addr);
    wire logic [2:0] write_idx = aw_addr[4:2];
    wire logic write_lane0 = w_strb[0];
    clock_pkg::field_write_t host_write;
    assign host_write.write = write_go && write_hit && write_lane0;
    assign host_write.field_index = write_idx;
    assign host_write.field_value = w_data[7:0] & field_mask(write_idx);

    // Read decode
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic read_hit = is_field_addr(s_axi_araddr);
    wire logic read_status = (s_axi_araddr == clock_pkg::ADDR_STATUS);
    wire logic [2:0] read_idx = s_axi_araddr[4:2];
    logic [7:0] read_byte;

    // Field selected by index; register fields run 0 to 6 from the top byte of the struct down
    always_comb begin
        case (read_idx)
            clock_pkg::IDX_SECONDS: read_byte = fields.seconds_count;
            clock_pkg::IDX_MINUTES: read_byte = fields.minutes_count;
            clock_pkg::IDX_HOURS: read_byte = fields.hours_count;
            clock_pkg::IDX_WEEKDAY: read_byte = fields.weekday_code;
            clock_pkg::IDX_DATE: read_byte = fields.day_of_month;
            clock_pkg::IDX_MONTH: read_byte = fields.month_count;
            clock_pkg::IDX_YEAR: read_byte = fields.year_count;
            default: read_byte = 8'h00;
        endcase
    end

    wire logic [31:0] read_word = read_hit ? {24'h00_0000, read_byte}
                                           : {31'h0000_0000, second_tick};

    // Timebase: one tick per second of aclk; the core must stay clocked
    // from the backup domain for counting to survive main power loss
    assign tick_total = TICK_CYCLES - 32'h0000_0001;
    wire logic tick_now = (tick_count == tick_total);

    // Cascaded BCD carries
    logic [7:0] sec_next, min_next, hour_next, wday_next, date_next, month_next, year_next;
    logic sec_carry, min_carry, hour_carry, date_carry, month_carry;
    logic wday_carry, year_carry;

    bcd_counter_step u_sec (
        .value(fields.seconds_count),
        .max_value(clock_pkg::MAX_SECONDS),
        .wrap_value(8'h00),
        .next_value(sec_next),
        .carry(sec_carry)
    );
    bcd_counter_step u_min (
        .value(fields.minutes_count),
        .max_value(clock_pkg::MAX_SECONDS),
        .wrap_value(8'h00),
        .next_value(min_next),
        .carry(min_carry)
    );
    bcd_counter_step u_hour (
        .value(fields.hours_count),
        .max_value(clock_pkg::MAX_HOURS),
        .wrap_value(8'h00),
        .next_value(hour_next),
        .carry(hour_carry)
    );
    bcd_counter_step u_wday (
        .value(fields.weekday_code),
        .max_value(clock_pkg::MAX_WEEKDAY),
        .wrap_value(clock_pkg::FIRST_DAY),
        .next_value(wday_next),
        .carry(wday_carry)
    );
    bcd_counter_step u_date (
        .value(fields.day_of_month),
        .max_value(clock_pkg::MAX_DATE),
        .wrap_value(clock_pkg::FIRST_DAY),
        .next_value(date_next),
        .carry(date_carry)
    );
    bcd_counter_step u_month (
        .value(fields.month_count),
        .max_value(clock_pkg::MAX_MONTH),
        .wrap_value(clock_pkg::FIRST_DAY),
        .next_value(month_next),
        .carry(month_carry)
    );
    bcd_counter_step u_year (
        .value(fields.year_count),
        .max_value(clock_pkg::MAX_YEAR),
        .wrap_value(8'h00),
        .next_value(year_next),
        .carry(year_carry)
    );

    wire logic step_min = tick_now && sec_carry;
    wire logic step_hour = step_min && min_carry;
    wire logic step_day = step_hour && hour_carry;
    wire logic step_month = step_day && date_carry;
    wire logic step_year = step_month && month_carry;

    // Host write wins over the tick for the written field
    always_comb begin
        next_fields = fields;
        if (tick_now) begin
            next_fields.seconds_count = sec_next;
        end
        if (step_min) begin
            next_fields.minutes_count = min_next;
        end
        if (step_hour) begin
            next_fields.hours_count = hour_next;
        end
        if (step_day) begin
            next_fields.weekday_code = wday_next;
            next_fields.day_of_month = date_next;
        end
        if (step_month) begin
            next_fields.month_count = month_next;
        end
        if (step_year) begin
            next_fields.year_count = year_next;
        end
        if (host_write.write) begin
            case (host_write.field_index)
                clock_pkg::IDX_SECONDS: next_fields.seconds_count = host_write.field_value;
                clock_pkg::IDX_MINUTES: next_fields.minutes_count = host_write.field_value;
                clock_pkg::IDX_HOURS: next_fields.hours_count = host_write.field_value;
                clock_pkg::IDX_WEEKDAY: next_fields.weekday_code = host_write.field_value;
                clock_pkg::IDX_DATE: next_fields.day_of_month = host_write.field_value;
                clock_pkg::IDX_MONTH: next_fields.month_count = host_write.field_value;
                clock_pkg::IDX_YEAR: next_fields.year_count = host_write.field_value;
                default: next_fields = next_fields;
            endcase
        end
    end

    // Field storage and timebase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fields <= {clock_pkg::RESET_SECONDS, clock_pkg::RESET_MINUTES, clock_pkg::RESET_HOURS,
                       clock_pkg::RESET_WEEKDAY, clock_pkg::RESET_DATE, clock_pkg::RESET_MONTH,
                       clock_pkg::RESET_YEAR};
            tick_count <= 32'h0000_0000;
            second_tick <= 1'b0;
        end else begin
            fields <= next_fields;
            tick_count <= tick_now ? 32'h0000_0000 : tick_count + 32'h0000_0001;
            second_tick <= tick_now;
        end
    end

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_awready;
            s_axi_wready <= !w_held && !w_take && !s_axi_wready;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= clock_pkg::RESP_OKAY;
        end else if (write_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? clock_pkg::RESP_OKAY : clock_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= clock_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= (read_hit || read_status) ? read_word : 32'h0000_0000;
                s_axi_rresp <= (read_hit || read_status) ? clock_pkg::RESP_OKAY : clock_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : bcd_calendar_clock

/* tb/clock_host_model.sv */
// Host model issuing AXI4-Lite field reads and writes
`timescale 1ns/1ns
module clock_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int hangs = 0;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        s_axi_awaddr <= 8'h00;
        s_axi_araddr <= 8'h00;
        s_axi_wdata <= 32'h0000_0000;
    end
    // Address and data inverted once taken, so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!s_axi_bvalid && n < 300);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 300) hangs++;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid && n < 300);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 300) hangs++;
        @(posedge aclk);
    endtask : rd
endmodule : clock_host_model

/* tb/bcd_calendar_clock_chk.sv */
// Checker for bus handshakes and second tick of the calendar clock
`timescale 1ns/1ns
module bcd_calendar_clock_chk #(
    parameter int unsigned TICK_CYCLES = clock_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic second_tick
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int unsigned gap;
    logic seen;
    always_ff @(posedge aclk) begin
        if (!aresetn || second_tick) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
        seen <= aresetn && (seen || second_tick);
    end
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles after");
    r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    tick_pulse_a: assert property (second_tick |=> !second_tick [*8])
        else $error("second tick too wide or too close");
    tick_period_a: assert property (second_tick && seen |-> gap == TICK_CYCLES - 1)
        else $error("second tick period wrong");
endmodule : bcd_calendar_clock_chk
bind bcd_calendar_clock bcd_calendar_clock_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .second_tick);

/* tb/tb_top.sv */
// Self-checking bench for the calendar clock core
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, second_tick;
    int err_count = 0;
    int tests_run = 0;
    bcd_calendar_clock #(.TICK_CYCLES(200)) uut (.*);
    clock_host_model host (.*);
    initial forever #4 aclk = ~aclk;
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic wf(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, {24'hff_ff00, 8'h00} | 32'(d), r);
        `CHK("bresp", er, r)
        if (host.hangs != 0) begin
            err_count++;
            finish_test();
        end
    endtask : wf
    task automatic rf(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        `CHK("rresp", er, r)
        `CHK("rdata", 32'(e), d)
        if (host.hangs != 0) begin
            err_count++;
            finish_test();
        end
    endtask : rf
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (second_tick !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            err_count++;
            finish_test();
        end
    endtask : wait_tick
    task automatic t_reset_values();
        logic [7:0] rv[7];
        rv = '{clock_pkg::RESET_SECONDS, clock_pkg::RESET_MINUTES, clock_pkg::RESET_HOURS,
            clock_pkg::RESET_WEEKDAY, clock_pkg::RESET_DATE, clock_pkg::RESET_MONTH, clock_pkg::RESET_YEAR};
        for (int i = 0; i < 7; i++) rf(8'(4 * i), rv[i], clock_pkg::RESP_OKAY);
    endtask : t_reset_values
    task automatic t_weekdays();
        for (int k = 1; k <= 7; k++) begin
            wf(8'h0c, 8'(k), clock_pkg::RESP_OKAY);
            rf(8'h0c, 8'(k), clock_pkg::RESP_OKAY);
        end
    endtask : t_weekdays
    task automatic t_masks();
        logic [7:0] m[7];
        m = '{clock_pkg::MASK_SECONDS, clock_pkg::MASK_MINUTES, clock_pkg::MASK_HOURS,
            clock_pkg::MASK_WEEKDAY, clock_pkg::MASK_DATE, clock_pkg::MASK_MONTH, clock_pkg::MASK_YEAR};
        wait_tick();
        for (int i = 0; i < 7; i++) begin
            wf(8'(4 * i), 8'hff, clock_pkg::RESP_OKAY);
            rf(8'(4 * i), m[i], clock_pkg::RESP_OKAY);
        end
    endtask : t_masks
    task automatic t_rollover();
        logic [7:0] pre[7];
        logic [7:0] post[7];
        pre = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
        post = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        wait_tick();
        for (int i = 6; i >= 0; i--) wf(8'(4 * i), pre[i], clock_pkg::RESP_OKAY);
        wait_tick();
        for (int i = 0; i < 7; i++) rf(8'(4 * i), post[i], clock_pkg::RESP_OKAY);
        wait_tick();
        rf(8'h00, 8'h01, clock_pkg::RESP_OKAY);
        wf(8'h00, 8'h19, clock_pkg::RESP_OKAY);
        wait_tick();
        rf(8'h00, 8'h20, clock_pkg::RESP_OKAY);
    endtask : t_rollover
    task automatic t_unmapped();
        wf(8'h20, 8'h59, clock_pkg::RESP_SLVERR);
        rf(8'h20, 8'h00, clock_pkg::RESP_SLVERR);
        // Status word reads clear well away from the tick pulse
        rf(clock_pkg::ADDR_STATUS, 8'h00, clock_pkg::RESP_OKAY);
    endtask : t_unmapped
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values();
        t_weekdays();
        t_masks();
        t_rollover();
        t_unmapped();
        finish_test();
    end
endmodule : tb_top
